// [hw/sdims_pkg.sv]
package sdims_pkg;
	// Register map
	localparam logic [7:0] REG_MODE = 8'h7C;
	localparam logic [7:0] REG_POWER = 8'h80;
	localparam logic [31:0] MODE_RESET = 32'h0000_0000;
	// Field positions
	localparam int INIT_MODE_LSB = 4;
	localparam int INIT_MODE_MSB = 6;
	localparam int TYPE_LSB = 0;
	localparam int TYPE_MSB = 1;
	localparam logic [1:0] TYPE_SDR = 2'h0;
	// Host address bits that form the mode register value
	localparam int MRS_ADDR_LSB = 3;
	localparam int MRS_ADDR_MSB = 15;
	localparam int MA_WIDTH = 13;
	// Power control bits in REG_POWER
	localparam int PWR_LOWPOWER_BIT = 0;
	localparam int PWR_SUSPEND_BIT = 1;
	localparam int PWR_SR_BIT = 2;
	localparam int PWR_BUSY_BIT = 3;

	typedef enum logic [2:0] {
		SDIMS_MODE_POST_RESET = 3'h0,
		SDIMS_MODE_NOP = 3'h1,
		SDIMS_MODE_PRECHARGE = 3'h2,
		SDIMS_MODE_MRS = 3'h3,
		SDIMS_MODE_RSVD4 = 3'h4,
		SDIMS_MODE_RSVD5 = 3'h5,
		SDIMS_MODE_CBR = 3'h6,
		SDIMS_MODE_NORMAL = 3'h7
	} sdims_mode_type;

	// SDRAM command encoding {cs_n, ras_n, cas_n, we_n}
	typedef enum logic [3:0] {
		SDIMS_CMD_DESEL = 4'h8,
		SDIMS_CMD_NOP = 4'h7,
		SDIMS_CMD_ACT = 4'h3,
		SDIMS_CMD_READ = 4'h5,
		SDIMS_CMD_WRITE = 4'h4,
		SDIMS_CMD_PRE = 4'h2,
		SDIMS_CMD_REF = 4'h1,
		SDIMS_CMD_MRS = 4'h0
	} sdims_cmd_type;

	typedef struct packed {
		logic valid;
		logic write;
		logic [31:0] addr;
	} sdims_req_type;

	typedef struct packed {
		sdims_cmd_type cmd;
		logic [MA_WIDTH-1:0] addr;
	} sdims_sdram_type;

	typedef enum logic [1:0] {
		SDIMS_PS_RUN = 2'h0,
		SDIMS_PS_FLUSH = 2'h1,
		SDIMS_PS_SELFREF = 2'h3,
		SDIMS_PS_EXIT = 2'h2
	} sdims_pstate_type;
endpackage

// [hw/sdims_sync.sv]
`timescale 1ns/100ps
`default_nettype none
// Two-stage synchroniser for a level from outside the clock domain
module sdims_sync
(
	input wire logic clk,
	input wire logic d,
	output logic q
);
	logic meta;
	logic next_meta;
	logic next_q;

	// Only the second stage is visible to logic
	always_comb
	begin
		next_meta = d;
		next_q = meta;
	end

	always_ff @(posedge clk)
	begin
		meta <= next_meta;
		q <= next_q;
	end
endmodule
`default_nettype wire

// [hw/sdims_top.sv]
// Summary of operation
// - A read/write three-bit init mode field sits at bits 6 to 4 of the mode register.
// - The init mode field clears to zero whenever any reset ends.
// - All clock enables are high while reset is active.
// - After reset the clock enables stay low until a nonzero mode is written, then all go high.
// - A suspend request flushes pending commands, then puts every row into self-refresh.
// - Resume from suspend resets the block, clearing the mode; clock enables are high in reset, then stay low until a nonzero mode write.
// - Entry to idle or standby sleep flushes pending commands and enters self-refresh.
// - Exit from those states leaves self-refresh and resumes normal work with no software action.
// - Mode 001 turns every memory cycle into a NOP command.
// - Mode 010 turns every memory cycle into a precharge-all command.
// - Mode 011 issues mode register set with host address 15:3 on memory address 12:0.
// - Mode 110 turns every memory cycle into a CAS-before-RAS refresh.
// - Mode 111 is normal reads and writes; 100 and 101 are reserved.
// - A read-only two-bit memory type field reads 00 for single data rate SDRAM.
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module sdims_top
#(
	parameter int ROWS = 4
)
(
	input wire logic CLOCK,
	input wire logic NRST,
	input wire logic [7:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WRITE,
	input wire logic REG_READ,
	output logic [31:0] REG_RDATA,
	input wire sdims_pkg::sdims_req_type HOST_REQ,
	output logic HOST_READY,
	input wire logic SUSPEND_REQ,
	input wire logic LOWPOWER_REQ,
	output logic [ROWS-1:0] CKE,
	output sdims_pkg::sdims_sdram_type SDRAM_OUT,
	output logic SELF_REFRESH
);
	logic suspend_sync;
	logic lowpower_sync;
	logic [2:0] memory_init_mode;
	logic [2:0] next_memory_init_mode;
	logic cke_on;
	logic next_cke_on;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	sdims_pkg::sdims_pstate_type pstate;
	sdims_pkg::sdims_pstate_type next_pstate;
	logic pending;
	logic next_pending;
	sdims_pkg::sdims_req_type held;
	sdims_pkg::sdims_req_type next_held;
	sdims_pkg::sdims_sdram_type sdram;
	sdims_pkg::sdims_sdram_type next_sdram;
	logic [1:0] memory_type_code;
	logic mode_write;
	logic [31:0] mode_word;
	logic [31:0] power_word;
	logic sleep_req;
	logic flush_done;

	// Power requests come from another power domain, so synchronise them
	sdims_sync u_sync_suspend
	(
		.clk(CLOCK),
		.d(SUSPEND_REQ),
		.q(suspend_sync)
	);

	sdims_sync u_sync_lowpower
	(
		.clk(CLOCK),
		.d(LOWPOWER_REQ),
		.q(lowpower_sync)
	);

	assign memory_type_code = sdims_pkg::TYPE_SDR;
	assign mode_write = REG_WRITE && (REG_ADDR == sdims_pkg::REG_MODE);
	assign sleep_req = suspend_sync || lowpower_sync;

	// Mode field and clock-enable latch
	always_comb
	begin
		next_memory_init_mode = memory_init_mode;
		next_cke_on = cke_on;
		if (mode_write)
		begin
			next_memory_init_mode =
				REG_WDATA[sdims_pkg::INIT_MODE_MSB:sdims_pkg::INIT_MODE_LSB];
			if (REG_WDATA[sdims_pkg::INIT_MODE_MSB:sdims_pkg::INIT_MODE_LSB]
				!= sdims_pkg::SDIMS_MODE_POST_RESET)
			begin
				next_cke_on = 1'b1;
			end
		end
	end

	// Resume from suspend is delivered as a reset on NRST, which clears both
	always_ff @(posedge CLOCK)
	begin
		if (!NRST)
		begin
			memory_init_mode <= sdims_pkg::SDIMS_MODE_POST_RESET;
			cke_on <= 1'b0;
		end
		else
		begin
			memory_init_mode <= next_memory_init_mode;
			cke_on <= next_cke_on;
		end
	end

	// CKE high while in reset; low in self-refresh so rows keep their data
	always_comb
	begin
		if (!NRST)
		begin
			CKE = {ROWS{1'b1}};
		end
		else if (cke_on && pstate != sdims_pkg::SDIMS_PS_SELFREF)
		begin
			CKE = {ROWS{1'b1}};
		end
		else
		begin
			CKE = {ROWS{1'b0}};
		end
	end

	// Host requests are taken only while running and nothing is held
	assign HOST_READY = (pstate == sdims_pkg::SDIMS_PS_RUN) && !pending && !sleep_req;

	// Flush ends once the last held cycle has gone out
	assign flush_done = (pstate == sdims_pkg::SDIMS_PS_FLUSH) && !pending;

	// Command issue; one command per host cycle, and a held cycle drains before sleep
	always_comb
	begin
		next_pending = pending;
		next_held = held;
		next_sdram.cmd = sdims_pkg::SDIMS_CMD_NOP;
		next_sdram.addr = sdram.addr;
		if (HOST_READY && HOST_REQ.valid)
		begin
			next_pending = 1'b1;
			next_held = HOST_REQ;
		end
		if (pending)
		begin
			next_pending = 1'b0;
			next_sdram.addr =
				held.addr[sdims_pkg::MRS_ADDR_MSB:sdims_pkg::MRS_ADDR_LSB];
			case (memory_init_mode)
				sdims_pkg::SDIMS_MODE_NOP:
				begin
					next_sdram.cmd = sdims_pkg::SDIMS_CMD_NOP;
				end
				sdims_pkg::SDIMS_MODE_PRECHARGE:
				begin
					next_sdram.cmd = sdims_pkg::SDIMS_CMD_PRE;
				end
				sdims_pkg::SDIMS_MODE_MRS:
				begin
					next_sdram.cmd = sdims_pkg::SDIMS_CMD_MRS;
				end
				sdims_pkg::SDIMS_MODE_CBR:
				begin
					next_sdram.cmd = sdims_pkg::SDIMS_CMD_REF;
				end
				sdims_pkg::SDIMS_MODE_NORMAL:
				begin
					next_sdram.cmd = held.write ? sdims_pkg::SDIMS_CMD_WRITE
						: sdims_pkg::SDIMS_CMD_READ;
				end
				default:
				begin
					// Reserved modes and the post-reset mode send nothing but NOP
					next_sdram.cmd = sdims_pkg::SDIMS_CMD_NOP;
				end
			endcase
		end
		else if (flush_done)
		begin
			// Refresh with CKE dropping at the same edge enters self-refresh
			next_sdram.cmd = sdims_pkg::SDIMS_CMD_REF;
		end
	end

	// Command path registers; reset parks the bus on NOP
	always_ff @(posedge CLOCK)
	begin
		if (!NRST)
		begin
			pending <= 1'b0;
			held <= '0;
			sdram.cmd <= sdims_pkg::SDIMS_CMD_NOP;
			sdram.addr <= '0;
		end
		else
		begin
			pending <= next_pending;
			held <= next_held;
			sdram <= next_sdram;
		end
	end

	// Power state; a request before any mode write is ignored, as CKE is still off
	always_comb
	begin
		next_pstate = pstate;
		case (pstate)
			sdims_pkg::SDIMS_PS_RUN:
			begin
				if (sleep_req && cke_on)
				begin
					next_pstate = sdims_pkg::SDIMS_PS_FLUSH;
				end
			end
			sdims_pkg::SDIMS_PS_FLUSH:
			begin
				if (flush_done)
				begin
					next_pstate = sdims_pkg::SDIMS_PS_SELFREF;
				end
			end
			sdims_pkg::SDIMS_PS_SELFREF:
			begin
				if (!sleep_req)
				begin
					next_pstate = sdims_pkg::SDIMS_PS_EXIT;
				end
			end
			sdims_pkg::SDIMS_PS_EXIT:
			begin
				// One cycle with CKE high before new host cycles are taken
				next_pstate = sdims_pkg::SDIMS_PS_RUN;
			end
			default:
			begin
				next_pstate = sdims_pkg::SDIMS_PS_RUN;
			end
		endcase
	end

	// Power state register
	always_ff @(posedge CLOCK)
	begin
		if (!NRST)
		begin
			pstate <= sdims_pkg::SDIMS_PS_RUN;
		end
		else
		begin
			pstate <= next_pstate;
		end
	end

	// SDRAM_OUT comes straight from registers, so the memory bus never glitches; SELF_REFRESH is decoded from pstate
	assign SDRAM_OUT = sdram;
	assign SELF_REFRESH = (pstate == sdims_pkg::SDIMS_PS_SELFREF);

	// Register read words; unused bits read zero
	always_comb
	begin
		mode_word = sdims_pkg::MODE_RESET;
		mode_word[sdims_pkg::INIT_MODE_MSB:sdims_pkg::INIT_MODE_LSB] = memory_init_mode;
		mode_word[sdims_pkg::TYPE_MSB:sdims_pkg::TYPE_LSB] = memory_type_code;
		power_word = 32'h0000_0000;
		power_word[sdims_pkg::PWR_LOWPOWER_BIT] = lowpower_sync;
		power_word[sdims_pkg::PWR_SUSPEND_BIT] = suspend_sync;
		power_word[sdims_pkg::PWR_SR_BIT] = SELF_REFRESH;
		power_word[sdims_pkg::PWR_BUSY_BIT] = pending;
	end

	// Unmapped reads return zero, so software can probe without side effects
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		if (REG_READ)
		begin
			case (REG_ADDR)
				sdims_pkg::REG_MODE: next_rdata = mode_word;
				sdims_pkg::REG_POWER: next_rdata = power_word;
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge CLOCK)
	begin
		if (!NRST)
		begin
			rdata <= 32'h0000_0000;
		end
		else
		begin
			rdata <= next_rdata;
		end
	end

	assign REG_RDATA = rdata;
endmodule
`default_nettype wire

// [dv/sdims_sva.sv]
`timescale 1ns/100ps
`default_nettype none
// Port-level checks of the init mode sequencer
module sdims_sva
#(
	parameter int ROWS = 4
)
(
	input wire logic CLOCK,
	input wire logic NRST,
	input wire logic [7:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WRITE,
	input wire logic REG_READ,
	input wire logic [31:0] REG_RDATA,
	input wire sdims_pkg::sdims_req_type HOST_REQ,
	input wire logic HOST_READY,
	input wire logic [ROWS-1:0] CKE,
	input wire sdims_pkg::sdims_sdram_type SDRAM_OUT,
	input wire logic SELF_REFRESH
);
	logic [2:0] mode;
	logic ever;
	wire logic wr = REG_WRITE && REG_ADDR == sdims_pkg::REG_MODE;
	wire logic wnz = wr && REG_WDATA[6:4] != 3'h0;
	wire logic take = HOST_REQ.valid && HOST_READY;
	wire logic [12:0] ha = HOST_REQ.addr[15:3];
	// Shadow of the mode field; ever stays set so a later write of 000 cannot mislead us
	always_ff @(posedge CLOCK)
	begin
		if (!NRST)
		begin
			mode <= 3'h0;
			ever <= 1'b0;
		end
		else if (wr)
		begin
			mode <= REG_WDATA[6:4];
			ever <= ever || wnz;
		end
	end
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!NRST);
	// A host cycle taken while a given mode is in force
	sequence s_take(logic [2:0] m); take && mode == m; endsequence
	property p_rst_cke; disable iff (1'b0) !NRST |-> &CKE; endproperty
	a_rst_cke: assert property (p_rst_cke) else $error("cke low in reset");
	property p_cke_off; !ever |-> CKE == '0; endproperty
	a_cke_off: assert property (p_cke_off) else $error("cke high before mode write");
	property p_cke_on; wnz |=> &CKE; endproperty
	a_cke_on: assert property (p_cke_on) else $error("cke not raised by mode write");
	property p_readback; REG_READ && REG_ADDR == 8'h7C |=> REG_RDATA == {25'h0, mode, 4'h0}; endproperty
	a_readback: assert property (p_readback) else $error("mode readback wrong");
	property p_pre; s_take(3'h2) |-> ##2 SDRAM_OUT.cmd == 4'h2 ##1 SDRAM_OUT.cmd == 4'h7; endproperty
	a_pre: assert property (p_pre) else $error("precharge not issued");
	property p_ref; s_take(3'h6) |-> ##2 SDRAM_OUT.cmd == 4'h1; endproperty
	a_ref: assert property (p_ref) else $error("refresh not issued");
	property p_mrs; s_take(3'h3) |-> ##2 SDRAM_OUT == {4'h0, $past(ha, 2)}; endproperty
	a_mrs: assert property (p_mrs) else $error("mode set wrong");
	property p_nop; take && mode inside {3'h0, 3'h1, 3'h4, 3'h5} |-> ##2 SDRAM_OUT.cmd == 4'h7; endproperty
	a_nop: assert property (p_nop) else $error("command in nop mode");
	property p_sleep; SELF_REFRESH |-> CKE == '0 && !HOST_READY; endproperty
	a_sleep: assert property (p_sleep) else $error("active in self refresh");
	property p_wake; $fell(SELF_REFRESH) |-> ##[0:4] &CKE && HOST_READY; endproperty
	a_wake: assert property (p_wake) else $error("no wake after sleep");
endmodule
bind sdims_top sdims_sva #(.ROWS(ROWS)) i_sva (.CLOCK, .NRST, .REG_ADDR, .REG_WDATA, .REG_WRITE,
	.REG_READ, .REG_RDATA, .HOST_REQ, .HOST_READY, .CKE, .SDRAM_OUT, .SELF_REFRESH);
`default_nettype wire

// [dv/sdims_sdram_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Memory rank stand-in: logs each command other than NOP for the bench
module sdims_sdram_model
(
	input wire logic clk,
	input wire sdims_pkg::sdims_sdram_type bus,
	output logic seen,
	output sdims_pkg::sdims_sdram_type got
);
	// Registered so the bench reads a settled copy one edge later
	always @(posedge clk)
	begin
		seen <= bus.cmd != sdims_pkg::SDIMS_CMD_NOP;
		got <= bus;
	end
endmodule
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic CLOCK = 1'b0, NRST = 1'b0, REG_WRITE = 1'b0, REG_READ = 1'b0, rd_d = 1'b0;
	logic SUSPEND_REQ = 1'b0, LOWPOWER_REQ = 1'b0, HOST_READY, SELF_REFRESH, seen;
	logic [7:0] REG_ADDR = 8'h00;
	logic [31:0] REG_WDATA = 32'h0, REG_RDATA, seed = 32'h9DD2, rq[$];
	logic [3:0] CKE;
	logic [12:0] last;
	logic [16:0] cq[$];
	sdims_pkg::sdims_req_type HOST_REQ = '0;
	sdims_pkg::sdims_sdram_type SDRAM_OUT, got;
	int num_errors = 0, compares = 0, cycles = 0;
	logic [3:0] ec [8] = '{4'h7, 4'h7, 4'h2, 4'h0, 4'h7, 4'h7, 4'h1, 4'h5};
	logic [2:0] order [7] = '{3'h1, 3'h2, 3'h6, 3'h3, 3'h4, 3'h5, 3'h7};
	always #20 CLOCK = ~CLOCK;
	sdims_top #(.ROWS(4)) i_dut (.CLOCK, .NRST, .REG_ADDR, .REG_WDATA, .REG_WRITE, .REG_READ,
		.REG_RDATA, .HOST_REQ, .HOST_READY, .SUSPEND_REQ, .LOWPOWER_REQ, .CKE, .SDRAM_OUT,
		.SELF_REFRESH);
	sdims_sdram_model i_mem (.clk(CLOCK), .bus(SDRAM_OUT), .seen, .got);
	// Fixed xorshift source so every run repeats
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic tally_and_finish();
		if (num_errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Register strobes last one cycle; the trailing edge keeps calls from colliding
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge CLOCK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WRITE <= 1'b1;
		@(posedge CLOCK);
		REG_WRITE <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] e);
		@(posedge CLOCK);
		REG_ADDR <= a;
		REG_READ <= 1'b1;
		rq.push_back(e);
		@(posedge CLOCK);
		REG_READ <= 1'b0;
	endtask
	// One memory cycle, held until taken, then a spare cycle for the spacing limit
	task automatic host(logic [2:0] m);
		logic [31:0] a;
		a = rnd();
		last = a[15:3];
		@(posedge CLOCK);
		HOST_REQ <= '{1'b1, a[0], a};
		if (ec[m] != 4'h7)
			cq.push_back({m == 3'h7 && a[0] ? 4'h4 : ec[m], a[15:3]});
		do @(posedge CLOCK); while (HOST_READY !== 1'b1);
		HOST_REQ.valid <= 1'b0;
		@(posedge CLOCK);
	endtask
	task automatic wait_sr(logic v);
		for (int i = 0; i < 40 && SELF_REFRESH !== v; i++)
			@(posedge CLOCK);
		chk("self_refresh", SELF_REFRESH, v);
	endtask
	// Results meet the oldest note; an empty queue turns a stray command into a mismatch
	always @(posedge CLOCK)
	begin
		if (rd_d === 1'b1)
			chk("rdata", REG_RDATA, rq.pop_front());
		if (seen === 1'b1)
			chk("sdram", got, cq.size() ? cq.pop_front() : 'x);
		rd_d <= REG_READ;
	end
	// Hang guard, far above the hundred or so cycles the sequence needs
	always @(posedge CLOCK)
		if (++cycles == 3000)
		begin
			num_errors++;
			tally_and_finish();
		end
	initial
	begin
		repeat (4) @(posedge CLOCK);
		chk("cke", CKE, 32'hF);
		NRST <= 1'b1;
		rd(sdims_pkg::REG_MODE, 32'h0);
		rd(8'h00, 32'h0);
		chk("cke", CKE, 32'h0);
		host(3'h0);
		foreach (order[k])
		begin
			wr(sdims_pkg::REG_MODE, rnd() & 32'hFFFF_FF8F | order[k] << 4);
			rd(sdims_pkg::REG_MODE, order[k] << 4);
			chk("cke", CKE, 32'hF);
			host(order[k]);
			host(order[k]);
		end
		LOWPOWER_REQ <= 1'b1;
		cq.push_back({4'h1, last});
		wait_sr(1'b1);
		chk("cke", CKE, 32'h0);
		rd(sdims_pkg::REG_POWER, 32'h5);
		LOWPOWER_REQ <= 1'b0;
		wait_sr(1'b0);
		repeat (4) @(posedge CLOCK);
		chk("cke", CKE, 32'hF);
		host(3'h7);
		SUSPEND_REQ <= 1'b1;
		cq.push_back({4'h1, last});
		wait_sr(1'b1);
		rd(sdims_pkg::REG_POWER, 32'h6);
		NRST <= 1'b0;
		SUSPEND_REQ <= 1'b0;
		repeat (4) @(posedge CLOCK);
		NRST <= 1'b1;
		rd(sdims_pkg::REG_MODE, 32'h0);
		chk("cke", CKE, 32'h0);
		repeat (4) @(posedge CLOCK);
		chk("pending", cq.size(), 32'h0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
